// ### sim_baseband_cards.sv
// model of the baseband card port and the two cards
module sim_baseband_cards (
	input wire logic core_clk,
	input wire logic clkRun,
	input wire logic clkIdle,
	input wire logic hostCardIoOut,
	input wire logic hostCardIoOe,
	input wire logic slot1CardIoOut,
	input wire logic slot1CardIoOe,
	input wire logic slot2CardIoOut,
	input wire logic slot2CardIoOe,
	output logic     hostCardClock,
	output logic     hostCardReset,
	output logic     hostCardIoIn,
	output logic     slot1CardIoIn,
	output logic     slot2CardIoIn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial hostCardClock = 1'b0;
	initial hostCardReset = 1'b0;
	// clock stands at the idle level between transfers, reset held low until running
	always @(posedge core_clk) begin
		hostCardClock <= clkRun ? ~hostCardClock : clkIdle;
		hostCardReset <= clkRun;
	end
	// open drain data lines with pull-ups, released by the far side
	assign hostCardIoIn  = hostCardIoOe ? hostCardIoOut : 1'b1;
	assign slot1CardIoIn = slot1CardIoOe ? slot1CardIoOut : 1'b1;
	assign slot2CardIoIn = slot2CardIoOe ? slot2CardIoOut : 1'b1;
endmodule : sim_baseband_cards

// ### sim_debounce.sv
// programmable debounce counter with filtered output and event pulse
`include "sim_switch_regs.svh"
module sim_debounce (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       inTrue,
	input  wire logic       forceZero,
	input  wire logic [7:0] reloadVal,
	output logic            filtered,
	output logic            riseEvt,
	output logic [7:0]      count
);
	logic [7:0] cnt_ff;
	logic       filt_ff;
	logic       quiet_ff;
	logic       evt_ff;
	wire        atZero = (cnt_ff == 8'h00);
	wire        rising = inTrue & tick & atZero & ~filt_ff & ~forceZero;

	// ----------------------------------------
	// counter and filtered output
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff   <= `DEB_COUNT_RESET;
			filt_ff  <= 1'b0;
			quiet_ff <= 1'b0;
		end else if (!inTrue) begin
			cnt_ff   <= reloadVal;
			filt_ff  <= 1'b0;
			quiet_ff <= 1'b0;
		end else if (forceZero) begin
			cnt_ff   <= 8'h00;
			quiet_ff <= 1'b1;
		end else if (tick) begin
			if (!atZero) begin
				cnt_ff <= cnt_ff - 8'h01;
			end else begin
				filt_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			evt_ff <= 1'b0;
		end else begin
			evt_ff <= rising & ~quiet_ff;
		end
	end

	assign filtered = filt_ff;
	assign riseEvt  = evt_ff;
	assign count    = cnt_ff;
endmodule : sim_debounce

// ### sim_slot_off.sv
// per slot automatic shutdown sequencer
module sim_slot_off (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 tick,
	input  wire logic                 start,
	input  wire logic                 staged,
	output sim_switch_pkg::card_lines_t killLines,
	output logic                      done
);
	sim_switch_pkg::shut_state_t state_ff;
	sim_switch_pkg::card_lines_t kill_ff;

	// ----------------------------------------
	// shutdown steps
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= sim_switch_pkg::SD_IDLE;
			kill_ff  <= '0;
		end else begin
			case (state_ff)
				sim_switch_pkg::SD_IDLE: begin
					if (start && staged) begin
						kill_ff.rst <= 1'b1;
						state_ff    <= sim_switch_pkg::SD_CLK;
					end else if (start) begin
						kill_ff  <= '1;
						state_ff <= sim_switch_pkg::SD_REG;
					end
				end
				sim_switch_pkg::SD_CLK: begin
					if (tick) begin
						kill_ff.clk <= 1'b1;
						state_ff    <= sim_switch_pkg::SD_IO;
					end
				end
				sim_switch_pkg::SD_IO: begin
					if (tick) begin
						kill_ff.io <= 1'b1;
						state_ff   <= sim_switch_pkg::SD_REG;
					end
				end
				sim_switch_pkg::SD_REG: begin
					if (tick) begin
						kill_ff  <= '0;
						state_ff <= sim_switch_pkg::SD_IDLE;
					end
				end
				default: begin
					state_ff <= sim_switch_pkg::SD_IDLE;
				end
			endcase
		end
	end

	assign killLines = kill_ff;
	assign done      = (state_ff == sim_switch_pkg::SD_REG) & tick;
endmodule : sim_slot_off

// ### sim_switch_ctrl.sv
// control logic of the dual slot card switch: registers, debounce, shutdown, line routing
`include "sim_switch_regs.svh"
module sim_switch_ctrl #(
	parameter int TICK_DIV = `CORE_CLK_HZ / `TIMER_HZ
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	input  wire logic       batteryPresenceInput,
	input  wire logic       shutdownInput,
	input  wire logic       ext32kClk,
	input  wire logic       clkSourceExt,
	input  wire logic       dirControlPin,
	input  wire logic       hostCardClock,
	input  wire logic       hostCardReset,
	input  wire logic       hostCardIoIn,
	output logic            hostCardIoOut,
	output logic            hostCardIoOe,
	output logic            slot1CardClock,
	output logic            slot1CardReset,
	input  wire logic       slot1CardIoIn,
	output logic            slot1CardIoOut,
	output logic            slot1CardIoOe,
	output logic            slot1SupplyEn,
	output logic            slot1SupplyHigh,
	output logic            slot2CardClock,
	output logic            slot2CardReset,
	input  wire logic       slot2CardIoIn,
	output logic            slot2CardIoOut,
	output logic            slot2CardIoOe,
	output logic            slot2SupplyEn,
	output logic            slot2SupplyHigh,
	output logic            batThresholdHigh,
	output logic            irqOut
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] slotCtrl_ff;
	logic [7:0] devCtrl_ff;
	logic [7:0] batCount_ff;
	logic [7:0] sdnCount_ff;
	logic [1:0] pend_ff;
	logic [7:0] rdData_ff;
	logic       polWrite_ff;
	logic       irq_ff;
	logic       thr_ff;
	logic       hostIoOut_ff;
	logic       hostIoOe_ff;
	logic [`TICK_CNT_W-1:0] tickCnt_ff;
	logic       extPrev_ff;

	wire wrStatus = 1'b0;
	wire wrCtrl   = regWrEn & (regAddr == `OFF_SLOT_CTRL);
	wire wrBatCnt = regWrEn & (regAddr == `OFF_BAT_COUNT);
	wire wrSdnCnt = regWrEn & (regAddr == `OFF_SDN_COUNT);
	wire wrDev    = regWrEn & (regAddr == `OFF_DEV_CTRL);
	wire rdStatus = regRdEn & (regAddr == `OFF_STATUS) & ~wrStatus;

	// ----------------------------------------
	// timing tick, internal divider or external clock
	// ----------------------------------------
	localparam logic [`TICK_CNT_W-1:0] TICK_LAST = `TICK_CNT_W'(TICK_DIV - 1);
	wire tickInt = (tickCnt_ff == TICK_LAST);
	wire tickExt = ext32kClk & ~extPrev_ff;
	wire tick    = clkSourceExt ? tickExt : tickInt;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tickCnt_ff <= '0;
			extPrev_ff <= 1'b0;
		end else begin
			tickCnt_ff <= tickInt ? '0 : tickCnt_ff + `TICK_CNT_W'(1);
			extPrev_ff <= ext32kClk;
		end
	end

	// ----------------------------------------
	// debounce filters
	// ----------------------------------------
	wire       sdnTrue  = (shutdownInput == devCtrl_ff[`DC_SDN_POL]);
	wire       batTrue  = batteryPresenceInput;
	wire       batFilt;
	wire       sdnFilt;
	wire       batEvt;
	wire       sdnEvt;
	wire [7:0] batNow;
	wire [7:0] sdnNow;

	sim_debounce batDeb (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.tick      (tick),
		.inTrue    (batTrue),
		.forceZero (1'b0),
		.reloadVal (batCount_ff),
		.filtered  (batFilt),
		.riseEvt   (batEvt),
		.count     (batNow)
	);

	sim_debounce sdnDeb (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.tick      (tick),
		.inTrue    (sdnTrue),
		.forceZero (polWrite_ff & sdnTrue),
		.reloadVal (sdnCount_ff),
		.filtered  (sdnFilt),
		.riseEvt   (sdnEvt),
		.count     (sdnNow)
	);

	// ----------------------------------------
	// automatic shutdown triggers
	// ----------------------------------------
	wire batStart = batEvt & ~devCtrl_ff[`DC_BAT_NOAUTO];
	wire sdnStart = sdnEvt & ~devCtrl_ff[`DC_SDN_NOAUTO];
	wire [1:0] trig = {batStart | sdnStart, batStart};

	// ----------------------------------------
	// io direction
	// ----------------------------------------
	wire dirFixed = devCtrl_ff[`DC_OE_CTRL];
	wire fixToCard = ~(dirControlPin ^ devCtrl_ff[`DC_OE_DIR]);
	wire allowToCard = ~dirFixed | fixToCard;
	wire allowToHost = ~dirFixed | ~fixToCard;
	wire [1:0] cardIoIn = {slot2CardIoIn, slot1CardIoIn};

	// ----------------------------------------
	// per slot lines, latch and shutdown
	// ----------------------------------------
	sim_switch_pkg::card_lines_t cardLines_ff [2];
	sim_switch_pkg::card_lines_t latch_ff [2];
	logic [1:0] wasStop_ff;
	logic [1:0] supEn_ff;
	logic [1:0] supHigh_ff;
	logic [1:0] ioOe_ff;
	wire  [1:0] active;
	wire  [1:0] stopped;
	wire  [1:0] done;
	wire  [1:0] latchIo;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_slot
			wire [3:0] field = slotCtrl_ff[gi*`SLOT_FIELD_W +: `SLOT_FIELD_W];
			wire modeLo = field[`F_MODE_LO];
			wire modeHi = field[`F_MODE_HI];
			wire powered = field[`F_REG_EN] | modeLo | modeHi;
			sim_switch_pkg::card_lines_t kill;
			sim_switch_pkg::card_lines_t live;
			sim_switch_pkg::card_lines_t nxt_lines;

			assign active[gi]  = modeLo & modeHi;
			assign stopped[gi] = modeLo & ~modeHi;
			assign latchIo[gi] = latch_ff[gi].io;

			sim_slot_off shut (
				.core_clk  (core_clk),
				.rst_n     (rst_n),
				.tick      (tick),
				.start     (trig[gi] & powered),
				.staged    (active[gi]),
				.killLines (kill),
				.done      (done[gi])
			);

			assign live.clk = hostCardClock;
			assign live.rst = hostCardReset;
			assign live.io  = hostCardIoIn | ~allowToCard;
			assign nxt_lines = (active[gi] ? live : stopped[gi] ?
			                    (wasStop_ff[gi] ? latch_ff[gi] : cardLines_ff[gi]) : '0) & ~kill;

			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					cardLines_ff[gi] <= '0;
					latch_ff[gi]     <= '0;
					wasStop_ff[gi]   <= 1'b0;
					supEn_ff[gi]     <= 1'b0;
					supHigh_ff[gi]   <= 1'b0;
					ioOe_ff[gi]      <= 1'b1;
				end else begin
					cardLines_ff[gi] <= nxt_lines;
					ioOe_ff[gi]      <= ~nxt_lines.io;
					wasStop_ff[gi]   <= stopped[gi];
					if (stopped[gi] && !wasStop_ff[gi]) begin
						latch_ff[gi] <= cardLines_ff[gi];
					end
					supEn_ff[gi]   <= field[`F_REG_EN] & ~done[gi];
					supHigh_ff[gi] <= field[`F_VOLT];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// host side data line
	// ----------------------------------------
	wire hostLevel = active[0]  ? (cardIoIn[0] | ~allowToHost) :
	                 active[1]  ? (cardIoIn[1] | ~allowToHost) :
	                 stopped[1] ? latchIo[1] :
	                 stopped[0] ? latchIo[0] : 1'b1;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	wire [7:0] ctrlBase = wrCtrl ? regWrData : slotCtrl_ff;
	wire [7:0] clrMask  = ({8{done[0]}} & `SLOT1_FIELDS) | ({8{done[1]}} & `SLOT2_FIELDS);
	wire [7:0] nxt_slotCtrl = ctrlBase & ~clrMask;
	wire batIrq = batEvt & devCtrl_ff[`DC_BAT_IRQ];
	wire sdnIrq = sdnEvt & devCtrl_ff[`DC_SDN_IRQ];
	wire [1:0] nxt_pend = ({sdnIrq, batIrq}) | (pend_ff & {2{~rdStatus}});
	wire polFlip = wrDev & (regWrData[`DC_SDN_POL] != devCtrl_ff[`DC_SDN_POL]);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			slotCtrl_ff <= `SLOT_CTRL_RESET;
			devCtrl_ff  <= `DEV_CTRL_RESET;
			batCount_ff <= `DEB_COUNT_RESET;
			sdnCount_ff <= `DEB_COUNT_RESET;
			pend_ff     <= 2'h0;
			polWrite_ff <= 1'b0;
			irq_ff      <= 1'b0;
			thr_ff      <= 1'b0;
		end else begin
			slotCtrl_ff <= nxt_slotCtrl;
			devCtrl_ff  <= wrDev ? regWrData : devCtrl_ff;
			batCount_ff <= wrBatCnt ? regWrData : batCount_ff;
			sdnCount_ff <= wrSdnCnt ? regWrData : sdnCount_ff;
			pend_ff     <= nxt_pend;
			polWrite_ff <= polFlip;
			irq_ff      <= |nxt_pend;
			thr_ff      <= devCtrl_ff[`DC_BAT_LEVEL];
		end
	end

	// ----------------------------------------
	// status and read mux
	// ----------------------------------------
	logic [7:0] status;
	always_comb begin
		status = `READ_ZERO;
		status[`ST_BAT_FILT] = batFilt;
		status[`ST_SDN_PEND] = pend_ff[1];
		status[`ST_SDN_FILT] = sdnFilt;
		status[`ST_BAT_PEND] = pend_ff[0];
		status[`ST_S1_LO]    = slotCtrl_ff[`F_MODE_LO];
		status[`ST_S1_HI]    = slotCtrl_ff[`F_MODE_HI];
		status[`ST_S2_LO]    = slotCtrl_ff[`SLOT_FIELD_W + `F_MODE_LO];
		status[`ST_S2_HI]    = slotCtrl_ff[`SLOT_FIELD_W + `F_MODE_HI];
	end

	wire [7:0] rdMux = (regAddr == `OFF_STATUS)    ? status      :
	                   (regAddr == `OFF_SLOT_CTRL) ? slotCtrl_ff :
	                   (regAddr == `OFF_BAT_COUNT) ? batCount_ff :
	                   (regAddr == `OFF_SDN_COUNT) ? sdnCount_ff :
	                   (regAddr == `OFF_DEV_CTRL)  ? devCtrl_ff  : `READ_ZERO;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdData_ff    <= `READ_ZERO;
			hostIoOut_ff <= 1'b0;
			hostIoOe_ff  <= 1'b0;
		end else begin
			rdData_ff    <= regRdEn ? rdMux : rdData_ff;
			hostIoOut_ff <= hostLevel;
			hostIoOe_ff  <= ~hostLevel;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign regRdData        = rdData_ff;
	assign irqOut           = irq_ff;
	assign batThresholdHigh = thr_ff;
	assign hostCardIoOut    = hostIoOut_ff;
	assign hostCardIoOe     = hostIoOe_ff;
	assign slot1CardClock   = cardLines_ff[0].clk;
	assign slot1CardReset   = cardLines_ff[0].rst;
	assign slot1CardIoOut   = cardLines_ff[0].io;
	assign slot1CardIoOe    = ioOe_ff[0];
	assign slot1SupplyEn    = supEn_ff[0];
	assign slot1SupplyHigh  = supHigh_ff[0];
	assign slot2CardClock   = cardLines_ff[1].clk;
	assign slot2CardReset   = cardLines_ff[1].rst;
	assign slot2CardIoOut   = cardLines_ff[1].io;
	assign slot2CardIoOe    = ioOe_ff[1];
	assign slot2SupplyEn    = supEn_ff[1];
	assign slot2SupplyHigh  = supHigh_ff[1];
endmodule : sim_switch_ctrl

// ### sim_switch_pkg.sv
// shared types of the dual slot switch
package sim_switch_pkg;
	typedef enum {SD_IDLE, SD_RST, SD_CLK, SD_IO, SD_REG} shut_state_t;
	typedef struct packed {
		logic clk;
		logic rst;
		logic io;
	} card_lines_t;
endpackage : sim_switch_pkg

// ### sim_switch_properties.sv
// port level assertions for the dual slot switch control
module sim_switch_checker #(
	parameter int TICK_DIV = 4
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic       batteryPresenceInput,
	input wire logic       slot1SupplyEn,
	input wire logic       slot1SupplyHigh,
	input wire logic       slot1CardClock,
	input wire logic       slot1CardReset,
	input wire logic       slot1CardIoOut,
	input wire logic       slot2SupplyEn,
	input wire logic       slot2CardClock,
	input wire logic       slot2CardReset,
	input wire logic       slot2CardIoOut,
	input wire logic       batThresholdHigh,
	input wire logic       irqOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic batSeen_ff;
	wire  nxt_batSeen = batteryPresenceInput | (batSeen_ff & slot1SupplyEn);
	wire  wr08        = regWrEn && regAddr == 8'h08;
	wire  wr0e        = regWrEn && regAddr == 8'h0e;
	wire  rd04        = regRdEn && regAddr == 8'h04;
	always_ff @(posedge core_clk) begin
		if (!rst_n) batSeen_ff <= 1'b0;
		else batSeen_ff <= nxt_batSeen;
	end
	property p_slot1Volt; $rose(slot1SupplyHigh) |-> $past(wr08 && regWrData[1], 2); endproperty
	a_slot1Volt: assert property (p_slot1Volt) else $error("high level without write");
	property p_slot1Supply; $rose(slot1SupplyEn) |-> $past(wr08 && regWrData[0], 2); endproperty
	a_slot1Supply: assert property (p_slot1Supply) else $error("supply on without write");
	property p_threshold; $changed(batThresholdHigh) |-> $past(wr0e) || $past(wr0e, 2); endproperty
	a_threshold: assert property (p_threshold) else $error("threshold moved alone");
	property p_irqClear; $fell(irqOut) |-> $past(rd04) || $past(rd04, 2); endproperty
	a_irqClear: assert property (p_irqClear) else $error("irq dropped without read");
	property p_batLow;
		rd04 && !batteryPresenceInput && !$past(batteryPresenceInput)
			&& !$past(batteryPresenceInput, 2) |=> !regRdData[0];
	endproperty
	a_batLow: assert property (p_batLow) else $error("filter high on false input");
	property p_slot1Kill;
		$fell(slot1SupplyEn) && !$past(wr08, 2) |-> !slot1CardReset && !slot1CardClock
			&& !slot1CardIoOut;
	endproperty
	a_slot1Kill: assert property (p_slot1Kill) else $error("slot 1 lines up at supply off");
	property p_slot2Kill;
		$fell(slot2SupplyEn) && !$past(wr08, 2) |-> !slot2CardReset && !slot2CardClock
			&& !slot2CardIoOut;
	endproperty
	a_slot2Kill: assert property (p_slot2Kill) else $error("slot 2 lines up at supply off");
	property p_slot1Spared; $fell(slot1SupplyEn) && !$past(wr08, 2) |-> batSeen_ff; endproperty
	a_slot1Spared: assert property (p_slot1Spared) else $error("slot 1 shut by pin");
endmodule : sim_switch_checker

bind sim_switch_ctrl sim_switch_checker #(.TICK_DIV(TICK_DIV)) sim_switch_checker_inst (
	.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
	.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
	.batteryPresenceInput(batteryPresenceInput), .slot1SupplyEn(slot1SupplyEn),
	.slot1SupplyHigh(slot1SupplyHigh), .slot1CardClock(slot1CardClock),
	.slot1CardReset(slot1CardReset), .slot1CardIoOut(slot1CardIoOut),
	.slot2SupplyEn(slot2SupplyEn), .slot2CardClock(slot2CardClock),
	.slot2CardReset(slot2CardReset), .slot2CardIoOut(slot2CardIoOut),
	.batThresholdHigh(batThresholdHigh), .irqOut(irqOut));

// ### sim_switch_regs.svh
// register offsets, field positions, reset values and timing for the dual slot switch
// Behaviour
// - control bit 1 picks slot 1 supply level, 0 low class, 1 high class.
// - control bit 0 set to 1 switches the slot 1 supply on.
// - slot 1 mode bits 2,3: 00 off, 11 active, 10 clock stop latches lines.
// - slot 2 mode bits 6,7: 00 off, 11 active, 10 clock stop.
// - status bits 6,7 echo slot 2 state: 00 off, 10 clock stop.
// - device control bit 0 clear means direction pin ignored, direction sensed automatically.
// - with no slot active, a clock-stopped slot presents its latched io level on the host side; slot 2 wins if both are stopped.
// - device control bit 3 picks the battery threshold; crossing it means removal.
// - filter reloads its count and drops its output on reset or false input.
// - true input decrements the counter on each timing tick, internal or external.
// - input change mid count reloads the counter and restarts counting.
// - a counter at zero raises its filtered output on the next timing tick.
// - battery input is true high; shutdown truth follows the polarity bit.
// - polarity write making shutdown true zeroes counter, no interrupt, no shutdown.
// - battery filter rising with device control bit 2 set raises the interrupt.
// - battery filter rising with device control bit 4 clear shuts both slots.
// - shutdown filter rising with device control bit 5 set raises the interrupt.
// - shutdown filter rising with device control bit 7 clear shuts slot 2 only.
// - clock stop slot: all lines low at once, supply off one tick later.
// - active slot shuts down staged; powered unselected slot shuts down instantly.
// - both debounce count registers reset to four.
// - both supplies reset to low level and disabled.
`ifndef SIM_SWITCH_REGS_SVH
`define SIM_SWITCH_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_STATUS      8'h04
`define OFF_SLOT_CTRL   8'h08
`define OFF_BAT_COUNT   8'h0a
`define OFF_SDN_COUNT   8'h0c
`define OFF_DEV_CTRL    8'h0e

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLOT_CTRL_RESET 8'h00
`define DEV_CTRL_RESET  8'h00
`define DEB_COUNT_RESET 8'h04
`define READ_ZERO       8'h00

// ----------------------------------------
// slot control fields, one nibble per slot
// ----------------------------------------
`define SLOT_FIELD_W    4
`define F_REG_EN        0
`define F_VOLT          1
`define F_MODE_LO       2
`define F_MODE_HI       3
`define SLOT1_FIELDS    8'h0f
`define SLOT2_FIELDS    8'hf0

// ----------------------------------------
// device control bits
// ----------------------------------------
`define DC_OE_CTRL      0
`define DC_OE_DIR       1
`define DC_BAT_IRQ      2
`define DC_BAT_LEVEL    3
`define DC_BAT_NOAUTO   4
`define DC_SDN_IRQ      5
`define DC_SDN_POL      6
`define DC_SDN_NOAUTO   7

// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_BAT_FILT     0
`define ST_SDN_PEND     1
`define ST_SDN_FILT     2
`define ST_BAT_PEND     3
`define ST_S1_LO        4
`define ST_S1_HI        5
`define ST_S2_LO        6
`define ST_S2_HI        7

// ----------------------------------------
// timing
// ----------------------------------------
`define CORE_CLK_HZ     200000000
`define TIMER_HZ        32000
`define TICK_CNT_W      13

`endif

// ### tb.sv
// self-checking testbench of the dual slot switch control
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk, rst_n, regWrEn, regRdEn, batteryPresenceInput, shutdownInput;
	logic       clkRun, clkIdle, hostCardClock, hostCardReset, hostCardIoIn;
	logic       hostCardIoOut, hostCardIoOe, batThresholdHigh, irqOut;
	logic       slot1CardClock, slot1CardReset, slot1CardIoIn, slot1CardIoOut, slot1CardIoOe;
	logic       slot2CardClock, slot2CardReset, slot2CardIoIn, slot2CardIoOut, slot2CardIoOe;
	logic       slot1SupplyEn, slot1SupplyHigh, slot2SupplyEn, slot2SupplyHigh;
	logic       ext32kClk, clkSourceExt;
	logic [7:0] regAddr, regWrData, regRdData;
	int         n_errors = 0;
	int         tests_run = 0;
	int         t1, t2;

	sim_switch_ctrl #(.TICK_DIV(4)) sim_switch_ctrl_inst (
		.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.batteryPresenceInput(batteryPresenceInput), .shutdownInput(shutdownInput),
		.ext32kClk(ext32kClk), .clkSourceExt(clkSourceExt), .dirControlPin(1'b0),
		.hostCardClock(hostCardClock), .hostCardReset(hostCardReset),
		.hostCardIoIn(hostCardIoIn), .hostCardIoOut(hostCardIoOut), .hostCardIoOe(hostCardIoOe),
		.slot1CardClock(slot1CardClock), .slot1CardReset(slot1CardReset),
		.slot1CardIoIn(slot1CardIoIn), .slot1CardIoOut(slot1CardIoOut),
		.slot1CardIoOe(slot1CardIoOe), .slot1SupplyEn(slot1SupplyEn),
		.slot1SupplyHigh(slot1SupplyHigh), .slot2CardClock(slot2CardClock),
		.slot2CardReset(slot2CardReset), .slot2CardIoIn(slot2CardIoIn),
		.slot2CardIoOut(slot2CardIoOut), .slot2CardIoOe(slot2CardIoOe),
		.slot2SupplyEn(slot2SupplyEn), .slot2SupplyHigh(slot2SupplyHigh),
		.batThresholdHigh(batThresholdHigh), .irqOut(irqOut));

	sim_baseband_cards sim_baseband_cards_inst (
		.core_clk(core_clk), .clkRun(clkRun), .clkIdle(clkIdle),
		.hostCardIoOut(hostCardIoOut), .hostCardIoOe(hostCardIoOe),
		.slot1CardIoOut(slot1CardIoOut), .slot1CardIoOe(slot1CardIoOe),
		.slot2CardIoOut(slot2CardIoOut), .slot2CardIoOe(slot2CardIoOe),
		.hostCardClock(hostCardClock), .hostCardReset(hostCardReset),
		.hostCardIoIn(hostCardIoIn), .slot1CardIoIn(slot1CardIoIn),
		.slot2CardIoIn(slot2CardIoIn));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge core_clk);
		regWrEn = 1'b0;
	endtask : wr

	task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge core_clk);
		regRdEn = 1'b0;
		check(regRdData, exp);
	endtask : rdCheck

	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask : settle

	task automatic waitOff(output int s1, output int s2);
		s1 = -1;
		s2 = -1;
		for (int i = 0; i < 300; i++) begin
			@(negedge core_clk);
			if (s1 < 0 && slot1SupplyEn === 1'b0) s1 = i;
			if (s2 < 0 && slot2SupplyEn === 1'b0) s2 = i;
		end
	endtask : waitOff

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end

	initial begin
		{rst_n, regWrEn, regRdEn, regAddr, regWrData} = '0;
		{batteryPresenceInput, shutdownInput, clkRun, clkIdle, ext32kClk, clkSourceExt} = 6'h10;
		settle(2);
		rst_n = 1'b1;
		// ----------------------------------------
		// reset values and unmapped read
		// ----------------------------------------
		rdCheck(8'h08, 8'h00);
		rdCheck(8'h0e, 8'h00);
		rdCheck(8'h0a, 8'h04);
		rdCheck(8'h0c, 8'h04);
		rdCheck(8'h20, 8'h00);
		rdCheck(8'h04, 8'h00);
		check({slot1SupplyEn, slot1SupplyHigh, slot2SupplyEn, slot2SupplyHigh, irqOut}, 8'h00);
		check({hostCardIoOut, hostCardIoOe, slot1CardIoOe, slot2CardIoOe}, 8'h0b);
		$display("test reset done");
		// ----------------------------------------
		// bring up, clock stop, switch, retry
		// ----------------------------------------
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h01);
		wr(8'h08, 8'h0d);
		settle(2);
		check({slot1SupplyEn, slot1SupplyHigh}, 8'h02);
		clkIdle = 1'b1;
		settle(3);
		check(slot1CardClock, 8'h01);
		wr(8'h08, 8'h05);
		clkIdle = 1'b0;
		settle(3);
		check(slot1CardClock, 8'h01);
		wr(8'h08, 8'hd5);
		settle(3);
		check({slot1CardClock, slot2CardClock}, 8'h02);
		rdCheck(8'h04, 8'hd0);
		wr(8'h08, 8'h55);
		rdCheck(8'h04, 8'h50);
		wr(8'h04, 8'hff);
		rdCheck(8'h04, 8'h50);
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h03);
		settle(2);
		check({slot1SupplyEn, slot1SupplyHigh}, 8'h03);
		$display("test slots done");
		// ----------------------------------------
		// battery debounce and shutdown
		// ----------------------------------------
		clkRun = 1'b1;
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h1d);
		wr(8'h0e, 8'h0c);
		settle(2);
		check(batThresholdHigh, 8'h01);
		batteryPresenceInput = 1'b1;
		settle(12);
		batteryPresenceInput = 1'b0;
		settle(2);
		batteryPresenceInput = 1'b1;
		settle(12);
		batteryPresenceInput = 1'b0;
		settle(2);
		check(slot1SupplyEn, 8'h01);
		batteryPresenceInput = 1'b1;
		waitOff(t1, t2);
		check(8'(t1 - t2), 8'h08);
		check(irqOut, 8'h01);
		check({slot1CardReset, slot1CardClock, slot1CardIoOut,
			slot2CardReset, slot2CardClock, slot2CardIoOut}, 8'h00);
		rdCheck(8'h08, 8'h00);
		rdCheck(8'h04, 8'h09);
		settle(3);
		check(irqOut, 8'h00);
		batteryPresenceInput = 1'b0;
		$display("test battery done");
		// ----------------------------------------
		// shutdown pin and polarity write
		// ----------------------------------------
		wr(8'h08, 8'h1d);
		wr(8'h0e, 8'h20);
		shutdownInput = 1'b0;
		waitOff(t1, t2);
		check({slot1SupplyEn, slot2SupplyEn, irqOut}, 8'h05);
		rdCheck(8'h04, 8'h36);
		shutdownInput = 1'b1;
		wr(8'h08, 8'h1d);
		wr(8'h0e, 8'h60);
		settle(40);
		check({irqOut, slot2SupplyEn}, 8'h01);
		rdCheck(8'h04, 8'h34);
		$display("test shutdown done");
		// ----------------------------------------
		// external timing clock selected
		// ----------------------------------------
		clkSourceExt = 1'b1;
		batteryPresenceInput = 1'b1;
		settle(40);
		rdCheck(8'h04, 8'h34);
		repeat (10) begin
			settle(2);
			ext32kClk = ~ext32kClk;
		end
		rdCheck(8'h04, 8'h35);
		$display("test ext clock done");
		give_verdict();
	end
endmodule : tb
